// ### rtl/gsec_pkg.sv
// Package with register map, field positions, reset values and timing constants.
package gsec_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NGRP   = 8;

    localparam logic [7:0] OFF_FLAGS  = 8'h02;
    localparam logic [7:0] OFF_POWER  = 8'h80;
    localparam logic [7:0] OFF_GLOBAL = 8'h81;
    localparam logic [7:0] OFF_CHAN   = 8'h82;
    localparam logic [7:0] OFF_TIMING = 8'h85;

    localparam int BAND_DIS_BIT  = 7;
    localparam int TP_RATE_LSB   = 4;
    localparam int TUNE_LP_BIT   = 3;
    localparam int TOUCH_SEL_LSB = 0;
    localparam int MASK_LSB      = 8;
    localparam int ACTIVE_LSB    = 0;
    localparam int RESEED_LSB    = 8;
    localparam int EVMODE_BIT    = 13;
    localparam int HALT_LSB      = 8;

    localparam logic [15:0] GLOBAL_RST = 16'h0000;
    localparam logic [15:0] CHAN_RST   = 16'h0000;
    localparam logic [7:0]  HALT_RST   = 8'hff;
    localparam logic [7:0]  HALT_NEVER = 8'hff;
    localparam logic [7:0]  EV_RESERVED = 8'h10;

    localparam logic [1:0] PM_NP  = 2'h0;
    localparam logic [1:0] PM_LP  = 2'h1;
    localparam logic [1:0] PM_ULP = 2'h2;

    localparam logic [2:0] TSEL_NONE = 3'h0;
    localparam logic [2:0] TSEL_WAKE = 3'h1;
    localparam logic [2:0] TSEL_TP2  = 3'h2;
    localparam logic [2:0] TSEL_TP3  = 3'h3;

    localparam logic [2:0] RATE_MAX_CODE = 3'h7;
    localparam logic [7:0] RATE_MAX      = 8'hff;

    localparam int HALT_STEP_MS     = 512;
    localparam int CLK_KHZ          = 40000;
    localparam int HALT_STEP_CYCLES = HALT_STEP_MS * CLK_KHZ;
endpackage

// ### rtl/global_sense_event_ctrl.sv
// Global sensing configuration, event mask, channel activation and reseed timer.
//
// Functional notes
// - Band-check disable bit stops band-triggered auto-tune.
// - Disabled band check ignores per-channel band bits.
// - Ultra-low-power trackpad average refresh every x samples.
// - Tune-only-low-power allows auto-tune in stable low power.
// - Touch output pin follows selected channel flag.
// - Masked event types set no flag, no ready.
// - Unmasked events except reserved type bit 4 set flag and signal ready.
// - Flags and ready repeat until flags read.
// - Up to 8 channels, one slot each.
// - Only wake channel senses in ultra-low power.
// - Reseed loads average with current counts.
// - Enabled channels reseed on halt timer expiry.
// - Events on enabled channels restart halt timer.
// - Steady enabled channels reseed all together.
// - Halt timeout steps 512 ms, 0xff never.
// - Event mode opens window only on unmasked event.
`timescale 1ns/1ps
module global_sense_event_ctrl #(
    parameter int HALT_STEP_CYCLES = gsec_pkg::HALT_STEP_CYCLES
) (
    input  wire logic                          CLK,
    input  wire logic                          RST,
    input  wire logic [gsec_pkg::ADDR_W-1:0]   ADDR,
    input  wire logic [gsec_pkg::DATA_W-1:0]   WDATA,
    input  wire logic                          WR,
    input  wire logic                          RD,
    output logic      [gsec_pkg::DATA_W-1:0]   RDATA,
    input  wire logic                          SAMPLE_DONE,
    input  wire logic                          WAKE_SAMPLE,
    input  wire logic [1:0]                    POWER_MODE,
    input  wire logic                          CH_STABLE,
    input  wire logic [7:0]                    EVENT_IN,
    input  wire logic [gsec_pkg::NGRP-1:0]     CH_EVENT,
    input  wire logic [gsec_pkg::NGRP-1:0]     CH_TOUCH,
    input  wire logic [gsec_pkg::NGRP-1:0]     BAND_OUT,
    input  wire logic [gsec_pkg::NGRP-1:0]     CH_BAND_EN,
    output logic                               RDY,
    output logic                               TOUCH_OUT,
    output logic                               TUNE_START,
    output logic                               TP_LTA_UPDATE,
    output logic      [gsec_pkg::NGRP-1:0]     SLOT_ENABLE,
    output logic      [gsec_pkg::NGRP-1:0]     RESEED
);
    localparam int STEP_W = $clog2(HALT_STEP_CYCLES + 1);

    logic [15:0]       global_reg, global_next;
    logic [15:0]       chan_reg, chan_next;
    logic              evmode_reg, evmode_next;
    logic [7:0]        halt_reg, halt_next;
    logic [7:0]        flags_reg, flags_next;
    logic [15:0]       rdata_next;
    logic              rdy_next, touch_next, tune_next, tpu_next;
    logic [7:0]        slot_next, reseed_next;
    logic [7:0]        rate_cnt_reg, rate_cnt_next;
    logic [STEP_W-1:0] step_reg, step_next;
    logic [7:0]        units_reg, units_next;
    logic [7:0]        mask, active, reseed_en, grp_act, band_hit, ev_acc, x_rate;
    logic [2:0]        tsel, rate_code;
    logic              band_dis, tune_lp, flag_rd, expire, restart;

    assign band_dis  = global_reg[gsec_pkg::BAND_DIS_BIT];
    assign tune_lp   = global_reg[gsec_pkg::TUNE_LP_BIT];
    assign tsel      = global_reg[gsec_pkg::TOUCH_SEL_LSB +: 3];
    assign rate_code = global_reg[gsec_pkg::TP_RATE_LSB +: 3];
    assign mask      = global_reg[gsec_pkg::MASK_LSB +: 8];
    assign active    = chan_reg[gsec_pkg::ACTIVE_LSB +: 8];
    assign reseed_en = chan_reg[gsec_pkg::RESEED_LSB +: 8];
    assign flag_rd   = RD && (ADDR == gsec_pkg::OFF_FLAGS);

    // Both trackpad layouts feed the single trackpad group position.
    assign grp_act = {active[7:4], 2'h0, active[2] | active[1], active[0]};

    genvar g;
    generate
        for (g = 0; g < gsec_pkg::NGRP; g++)
        begin : g_band
            assign band_hit[g] = BAND_OUT[g] & CH_BAND_EN[g] & grp_act[g];
        end
    endgenerate

    // Code 7 saturates at 255 instead of doubling to 256.
    assign x_rate = (rate_code == gsec_pkg::RATE_MAX_CODE) ? gsec_pkg::RATE_MAX
                  : 8'(8'h02 << rate_code);

    assign ev_acc  = EVENT_IN & ~mask & ~gsec_pkg::EV_RESERVED;
    assign restart = |(CH_EVENT & reseed_en) || halt_reg == gsec_pkg::HALT_NEVER;
    // Compare with >= so that a timeout shortened in mid-count still expires at once.
    assign expire  = !restart && units_reg >= halt_reg;

    // Writes land at the end of the strobe cycle. Unmapped offsets and the read-only
    // flag register drop the write silently.
    always_comb
    begin
        global_next = global_reg;
        chan_next   = chan_reg;
        evmode_next = evmode_reg;
        halt_next   = halt_reg;
        if (WR)
        begin
            case (ADDR)
                gsec_pkg::OFF_POWER:  evmode_next = WDATA[gsec_pkg::EVMODE_BIT];
                gsec_pkg::OFF_GLOBAL: global_next = WDATA;
                gsec_pkg::OFF_CHAN:   chan_next = WDATA;
                gsec_pkg::OFF_TIMING: halt_next = WDATA[gsec_pkg::HALT_LSB +: 8];
                default: ;
            endcase
        end
        // Read data stand for one cycle only, so an idle cycle returns zero and a stale
        // word can never be taken for an answer.
        rdata_next = 16'h0000;
        if (RD)
        begin
            case (ADDR)
                gsec_pkg::OFF_FLAGS:  rdata_next = {8'h00, flags_reg};
                gsec_pkg::OFF_POWER:  rdata_next = 16'(evmode_reg) << gsec_pkg::EVMODE_BIT;
                gsec_pkg::OFF_GLOBAL: rdata_next = global_reg & ~(16'(gsec_pkg::EV_RESERVED) << gsec_pkg::MASK_LSB);
                gsec_pkg::OFF_CHAN:   rdata_next = chan_reg;
                gsec_pkg::OFF_TIMING: rdata_next = {halt_reg, 8'h00};
                default:              rdata_next = 16'h0000;
            endcase
        end
    end

    always_comb
    begin
        // A new event beats the read that clears the flags in the same cycle.
        flags_next = (flag_rd ? 8'h00 : flags_reg) | ev_acc;
        rdy_next = SAMPLE_DONE && (!evmode_reg || flags_next != 8'h00);
        // Codes 4 to 7 line up with the group index of the generic and Hall groups,
        // so the code itself picks the flag.
        case (tsel)
            gsec_pkg::TSEL_NONE: touch_next = 1'b0;
            gsec_pkg::TSEL_WAKE: touch_next = CH_TOUCH[0];
            gsec_pkg::TSEL_TP2,
            gsec_pkg::TSEL_TP3:  touch_next = CH_TOUCH[1];
            default:             touch_next = CH_TOUCH[tsel];
        endcase
        tune_next = !band_dis && band_hit != 8'h00
                    && (!tune_lp || (POWER_MODE == gsec_pkg::PM_LP && CH_STABLE));
        // Each active bit is one slot; the sequencer times them apart.
        slot_next = (POWER_MODE == gsec_pkg::PM_ULP) ? (active & 8'h01) : active;
    end

    // The counter restarts whenever the part leaves ultra-low power, so the first
    // refresh after a wake-up always waits for a full x samples.
    always_comb
    begin
        rate_cnt_next = rate_cnt_reg;
        tpu_next = 1'b0;
        if (POWER_MODE != gsec_pkg::PM_ULP)
            rate_cnt_next = 8'h00;
        else if (WAKE_SAMPLE)
        begin
            if (rate_cnt_reg + 8'h01 >= x_rate)
            begin
                rate_cnt_next = 8'h00;
                tpu_next = 1'b1;
            end
            else
                rate_cnt_next = rate_cnt_reg + 8'h01;
        end
    end

    // One halt unit is HALT_STEP_CYCLES clocks. A restart drops the partial unit too,
    // which costs up to one unit of accuracy but keeps a single comparison.
    always_comb
    begin
        step_next   = step_reg;
        units_next  = units_reg;
        reseed_next = 8'h00;
        if (restart || expire)
        begin
            step_next  = '0;
            units_next = 8'h00;
            // The sensing engine loads each pulsed group's average with its counts.
            reseed_next = expire ? reseed_en : 8'h00;
        end
        else if (step_reg == STEP_W'(HALT_STEP_CYCLES - 1))
        begin
            step_next  = '0;
            units_next = units_reg + 8'h01;
        end
        else
            step_next = step_reg + STEP_W'(1);
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            global_reg    <= gsec_pkg::GLOBAL_RST;
            chan_reg      <= gsec_pkg::CHAN_RST;
            evmode_reg    <= 1'b0;
            halt_reg      <= gsec_pkg::HALT_RST;
            flags_reg     <= 8'h00;
            RDATA         <= 16'h0000;
            RDY           <= 1'b0;
            TOUCH_OUT     <= 1'b0;
            TUNE_START    <= 1'b0;
            TP_LTA_UPDATE <= 1'b0;
            SLOT_ENABLE   <= 8'h00;
            RESEED        <= 8'h00;
            rate_cnt_reg  <= 8'h00;
            step_reg      <= '0;
            units_reg     <= 8'h00;
        end
        else
        begin
            global_reg    <= global_next;
            chan_reg      <= chan_next;
            evmode_reg    <= evmode_next;
            halt_reg      <= halt_next;
            flags_reg     <= flags_next;
            RDATA         <= rdata_next;
            RDY           <= rdy_next;
            TOUCH_OUT     <= touch_next;
            TUNE_START    <= tune_next;
            TP_LTA_UPDATE <= tpu_next;
            SLOT_ENABLE   <= slot_next;
            RESEED        <= reseed_next;
            rate_cnt_reg  <= rate_cnt_next;
            step_reg      <= step_next;
            units_reg     <= units_next;
        end
    end

    // Every output is registered, so each check looks one cycle after its cause.
    // Checks that read back a past input use the input as it stood at that cause.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_band_off_tune:
        assert property (band_dis |=> !TUNE_START) else $error("tune started with band check off");
    a_band_bits_used:
        assert property (!band_dis && !tune_lp && band_hit != 8'h00 |=> TUNE_START)
        else $error("enabled band hit did not start tune");
    a_tp_rate_count:
        assert property (POWER_MODE == gsec_pkg::PM_ULP && WAKE_SAMPLE && rate_code == 3'h0
                         && rate_cnt_reg == 8'h01 |=> TP_LTA_UPDATE)
        else $error("trackpad refresh not after 2 samples");
    a_tune_lp_only:
        assert property (tune_lp && !(POWER_MODE == gsec_pkg::PM_LP && CH_STABLE) |=> !TUNE_START)
        else $error("tune outside stable low power");
    a_touch_route:
        assert property (tsel == gsec_pkg::TSEL_WAKE && !WR |=> TOUCH_OUT == $past(CH_TOUCH[0]))
        else $error("touch pin not following wake channel");
    a_mask_blocks:
        assert property ((flags_reg & ~$past(flags_reg) & $past(mask)) == 8'h00)
        else $error("masked event set a flag");
    a_unmasked_sets:
        assert property (ev_acc != 8'h00 |=> (flags_reg & $past(ev_acc)) == $past(ev_acc))
        else $error("unmasked event lost");
    a_flags_hold:
        assert property (!flag_rd |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
        else $error("flag dropped without read");
    a_rdy_repeat:
        assert property (SAMPLE_DONE && flags_reg != 8'h00 && !flag_rd |=> RDY) else $error("ready not repeated");
    a_rdy_quiet:
        assert property (evmode_reg && flags_reg == 8'h00 && ev_acc == 8'h00 |=> !RDY)
        else $error("event-mode window without event");
    a_ulp_slots:
        assert property (POWER_MODE == gsec_pkg::PM_ULP |=> SLOT_ENABLE[7:1] == 7'h00)
        else $error("non-wake slot in ultra low power");
    a_halt_never:
        assert property (halt_reg == gsec_pkg::HALT_NEVER |=> RESEED == 8'h00) else $error("reseed with timeout off");
    a_reseed_group:
        assert property (expire |=> RESEED == $past(reseed_en)) else $error("reseed mask wrong");
    a_halt_restart:
        assert property (|(CH_EVENT & reseed_en) |=> RESEED == 8'h00 && units_reg == 8'h00)
        else $error("halt timer not restarted");
    a_tp_quiet:
        assert property (!(POWER_MODE == gsec_pkg::PM_ULP && WAKE_SAMPLE) |=> !TP_LTA_UPDATE)
        else $error("trackpad refresh without wake sample");
    a_touch_none:
        assert property (tsel == gsec_pkg::TSEL_NONE |=> !TOUCH_OUT)
        else $error("touch pin driven with no channel selected");
    a_touch_group:
        assert property (!WR && tsel >= 3'h4 |=> TOUCH_OUT == $past(CH_TOUCH[tsel]))
        else $error("touch pin not following generic or hall group");
    a_tune_no_hit:
        assert property (band_hit == 8'h00 |=> !TUNE_START)
        else $error("tune started without enabled band hit");
    a_slots_active:
        assert property (POWER_MODE != gsec_pkg::PM_ULP |=> SLOT_ENABLE == $past(active))
        else $error("slot enables differ from active groups");
    a_wake_slot:
        assert property (POWER_MODE == gsec_pkg::PM_ULP |=> SLOT_ENABLE[0] == $past(active[0]))
        else $error("wake slot lost in ultra low power");
    a_reserved_flag:
        assert property (flags_reg[4] == 1'b0)
        else $error("reserved event type set a flag");
    a_stream_rdy:
        assert property (!evmode_reg && SAMPLE_DONE |=> RDY)
        else $error("streaming mode sample gave no window");
    a_rdy_sample:
        assert property (!SAMPLE_DONE |=> !RDY)
        else $error("ready without finished sample");
    a_flag_clear:
        assert property (flag_rd && ev_acc == 8'h00 |=> flags_reg == 8'h00)
        else $error("flags not cleared by read");

    c_masked_event: cover property (EVENT_IN != 8'h00 && (EVENT_IN & ~mask) == 8'h00);
    c_flag_read:    cover property (flags_reg != 8'h00 ##1 flag_rd ##1 flags_reg == 8'h00);
    c_reseed:       cover property (RESEED != 8'h00);
    c_tp_update:    cover property (TP_LTA_UPDATE);
    c_event_window: cover property (evmode_reg && RDY);
endmodule

// ### verification/host_model.sv
// Host processor model that drives the register port of the controller.
`timescale 1ns/1ps
module host_model (
    input  wire logic                        clk,
    output logic [gsec_pkg::ADDR_W-1:0] addr,
    output logic [gsec_pkg::DATA_W-1:0] wdata,
    output logic                        wr,
    output logic                        rd,
    input  wire logic [gsec_pkg::DATA_W-1:0] rdata
);
    initial
    begin
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask
    // Reading the flag register is what ends repeated ready pulses.
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule

// ### verification/tb.sv
// Self-checking testbench for the global sensing and event block.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    logic        clk, rst, sd, ws, stab, tch_o, rdy, tune, tpu;
    logic [1:0]  pm;
    logic [7:0]  addr, ev, che, cht, bo, be, slot, rsd;
    logic [15:0] wdata, rdata, d;
    logic        wr, rd, r;
    int          errors, tests_run, n;
    host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    global_sense_event_ctrl #(.HALT_STEP_CYCLES(4)) uut (.CLK(clk), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SAMPLE_DONE(sd), .WAKE_SAMPLE(ws),
        .POWER_MODE(pm), .CH_STABLE(stab), .EVENT_IN(ev), .CH_EVENT(che), .CH_TOUCH(cht),
        .BAND_OUT(bo), .CH_BAND_EN(be), .RDY(rdy), .TOUCH_OUT(tch_o), .TUNE_START(tune),
        .TP_LTA_UPDATE(tpu), .SLOT_ENABLE(slot), .RESEED(rsd));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        host.read_reg(a, d);
        `CHK(d, e)
    endtask
    task automatic pulse_ev(input logic [7:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 8'h00;
    endtask
    task automatic sample(output logic q);
        @(posedge clk);
        sd <= 1'b1;
        @(posedge clk);
        sd <= 1'b0;
        #1;
        q = rdy;
    endtask
    task automatic t_regs;
        rd_chk(8'h81, 16'h0000);
        rd_chk(8'h82, 16'h0000);
        rd_chk(8'h85, 16'hff00);
        rd_chk(8'h10, 16'h0000);
        host.write_reg(8'h81, 16'hffff);
        rd_chk(8'h81, 16'hefff);
        host.write_reg(8'h82, 16'h11f1);
        rd_chk(8'h82, 16'h11f1);
        `CHK(slot, 8'hf1)
    endtask
    task automatic t_touch;
        logic [7:0] oh [8];
        oh = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h10, 8'h20, 8'h40, 8'h80};
        for (int s = 0; s < 8; s++)
        begin
            host.write_reg(8'h81, 16'(s));
            cht <= (s == 0) ? 8'hff : oh[s];
            tick(2);
            `CHK(tch_o, s != 0)
            cht <= ~oh[s];
            tick(2);
            `CHK(tch_o, 1'b0)
        end
    endtask
    task automatic t_tune;
        host.write_reg(8'h82, 16'h00ff);
        bo <= 8'hff;
        host.write_reg(8'h81, 16'h0080);
        tick(2);
        `CHK(tune, 1'b0)
        host.write_reg(8'h81, 16'h0000);
        tick(2);
        `CHK(tune, 1'b1)
        host.write_reg(8'h81, 16'h0008);
        tick(2);
        `CHK(tune, 1'b0)
        pm <= gsec_pkg::PM_LP;
        stab <= 1'b1;
        tick(2);
        `CHK(tune, 1'b1)
        stab <= 1'b0;
        tick(2);
        `CHK(tune, 1'b0)
        bo <= 8'h00;
        pm <= gsec_pkg::PM_NP;
    endtask
    task automatic t_events;
        host.write_reg(8'h80, 16'h2000);
        host.write_reg(8'h81, 16'h0200);
        pulse_ev(8'h02);
        sample(r);
        `CHK(r, 1'b0)
        rd_chk(8'h02, 16'h0000);
        pulse_ev(8'h01);
        sample(r);
        `CHK(r, 1'b1)
        sample(r);
        `CHK(r, 1'b1)
        rd_chk(8'h02, 16'h0001);
        sample(r);
        `CHK(r, 1'b0)
    endtask
    task automatic t_tp;
        int x [8];
        x = '{2, 4, 8, 16, 32, 64, 128, 255};
        for (int i = 0; i < 8; i++)
        begin
            pm <= gsec_pkg::PM_NP;
            host.write_reg(8'h81, 16'({3'(i), 4'h0}));
            pm <= gsec_pkg::PM_ULP;
            n = 0;
            repeat (2 * x[i])
            begin
                @(posedge clk);
                ws <= 1'b1;
                @(posedge clk);
                ws <= 1'b0;
                #1;
                n += tpu;
            end
            `CHK(n, 2)
        end
        `CHK(slot, 8'h01)
        pm <= gsec_pkg::PM_NP;
    endtask
    task automatic t_reset;
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        rd_chk(8'h80, 16'h0000);
        rd_chk(8'h81, 16'h0000);
        rd_chk(8'h82, 16'h0000);
        rd_chk(8'h85, 16'hff00);
    endtask
    task automatic t_halt;
        host.write_reg(8'h82, 16'h1100);
        host.write_reg(8'h85, 16'h0100);
        n = 0;
        for (int i = 0; i < 12 && n == 0; i++)
        begin
            tick(1);
            if (rsd !== 8'h00) n = 1;
        end
        `CHK(rsd, 8'h11)
        for (int k = 0; k < 3; k++)
        begin
            // Group 1 has no reseed enable, so its events must not hold the timer.
            if (k == 2) host.write_reg(8'h85, 16'hff00);
            n = 0;
            repeat (15)
            begin
                @(posedge clk);
                che <= (k == 0) ? 8'h01 : (k == 1) ? 8'h02 : 8'h01;
                @(posedge clk);
                che <= 8'h00;
                #1;
                n |= (rsd != 8'h00);
            end
            `CHK(n, (k == 1))
        end
    endtask
    task automatic report_and_stop;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #500000;
        errors++;
        report_and_stop();
    end
    initial
    begin
        errors = 0;
        tests_run = 0;
        rst = 1'b1;
        {sd, ws, stab, pm, ev, che, cht, bo} = '0;
        be = 8'hff;
        tick(5);
        rst <= 1'b0;
        t_regs();
        t_touch();
        t_tune();
        t_events();
        t_tp();
        t_halt();
        t_reset();
        report_and_stop();
    end
endmodule
